// >>> hdl/ddr3_ctl_map.vh
// Constants for the DDR3 command and control input block
`ifndef DDR3_CTL_MAP_VH
`define DDR3_CTL_MAP_VH
// Decoded command codes, {cs_n, ras_n, cas_n, we_n}
`define CMD_MRS 4'h0
`define CMD_REF 4'h1
`define CMD_PRE 4'h2
`define CMD_ACT 4'h3
`define CMD_WR 4'h4
`define CMD_RD 4'h5
`define CMD_ZQC 4'h6
`define CMD_NOP 4'h7
// Command output code used when the command is masked or ignored
`define CMD_DESEL 4'h8
// Power states
`define PS_ACTIVE 2'h0
`define PS_PRE_PD 2'h1
`define PS_ACT_PD 2'h2
`define PS_SELF_REF 2'h3
// Bank count and bank address width
`define BANK_COUNT 8
`define BANK_BITS 3
// Precharge all selector position in the address
`define ADDR_AP_BIT 10
// Mode register fields
`define MR1_RTT_LO 2
`define MR1_RTT_MID 6
`define MR1_RTT_HI 9
`define MR2_RTTWR_LO 9
`define MR2_RTTWR_HI 10
`define MR2_AUTO_SR_BIT 6
`define MR2_SRT_BIT 7
`define MR_SEL_1 3'h1
`define MR_SEL_2 3'h2
`endif

// >>> hdl/pin_sync.v
// Two flip-flop synchroniser for a bundle of pin inputs
`timescale 1ns/1ns
module pin_sync #(
	parameter WIDTH = 1
) (
	// Clock and reset
	input wire ref_clk_in,
	input wire reset_in,
	// Data
	input wire [WIDTH-1:0] async_in,
	output reg [WIDTH-1:0] sync_out
);
	reg [WIDTH-1:0] meta_r;
	always @(posedge ref_clk_in)
	begin
		if (reset_in)
		begin
			meta_r <= {WIDTH{1'b0}};
			sync_out <= {WIDTH{1'b0}};
		end
		else
		begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule

// >>> hdl/cmd_decode.v
// Command decoder from chip select and the three command strobes
`timescale 1ns/1ns
`include "ddr3_ctl_map.vh"
module cmd_decode (
	// Strobes, active low
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	// Decoded command
	output reg [3:0] cmd_out
);
	always @*
	begin
		if (cs_n_in)
			cmd_out = `CMD_DESEL;
		else
			cmd_out = {1'b0, ras_n_in, cas_n_in, we_n_in};
	end
endmodule

// >>> hdl/ddr3_ctl_pins.v
// DDR3 command and control input side: sampling, power states and termination
`timescale 1ns/1ns
`include "ddr3_ctl_map.vh"

////////////////////////////////////////////////////////////////////////////////
// Overview of operation
// - Sample every control input where true clock rises (complement falls).
// - Clock enable high runs clocks, buffers, drivers; low stops them.
// - Clock enable low enters precharge or self-refresh idle, active power-down otherwise.
// - Rising clock enable exits self-refresh without needing a clock edge.
// - Power-down keeps only clock pair, termination control and clock enable buffers.
// - Self-refresh keeps only the clock enable buffer alive.
// - Chip select high on an edge masks that edge's command.
// - Command decoded from chip select, row, column and write strobes.
// - Registered termination control high enables termination on data, strobes, masks.
// - Termination control ignored when mode registers disable it or in self-refresh.
// - Active-low reset clears state while low; held high normally.
module ddr3_ctl_pins #(
	parameter ADDR_W = 14
) (
	// Clock and reset
	input wire ref_clk_in,
	input wire reset_in,
	// Memory pins from the controller
	input wire reset_n_pin_in,
	input wire ck_in,
	input wire ck_n_in,
	input wire cke_in,
	input wire cs_n_in,
	input wire ras_n_in,
	input wire cas_n_in,
	input wire we_n_in,
	input wire odt_in,
	input wire [`BANK_BITS-1:0] bank_in,
	input wire [ADDR_W-1:0] addr_in,
	// Decoded command, one pulse per link edge with chip select low accepted in the active state
	output reg cmd_valid_out,
	output reg [3:0] cmd_out,
	output reg [`BANK_BITS-1:0] cmd_bank_out,
	output reg [ADDR_W-1:0] cmd_addr_out,
	// Power and buffer state
	output reg [1:0] power_state_out,
	output reg int_clk_en_out,
	output reg out_drv_en_out,
	output reg cmd_buf_en_out,
	output reg ck_buf_en_out,
	output reg odt_buf_en_out,
	// Termination and status
	output reg term_en_out,
	output reg [`BANK_COUNT-1:0] bank_open_out,
	output reg auto_self_refresh_out,
	output reg ext_temp_sr_out
);
	////////////////////////////////////////////////////////////////////////////
	// Pin synchronisation
	wire [ADDR_W+`BANK_BITS+8:0] raw_w;
	wire [ADDR_W+`BANK_BITS+8:0] syn_w;
	assign raw_w = {reset_n_pin_in, ck_in, ck_n_in, cke_in, cs_n_in, ras_n_in,
		cas_n_in, we_n_in, odt_in, bank_in, addr_in};
	pin_sync #(
		.WIDTH(ADDR_W+`BANK_BITS+9)
	) u_sync (
		.ref_clk_in(ref_clk_in),
		.reset_in(reset_in),
		.async_in(raw_w),
		.sync_out(syn_w)
	);
	wire s_rst_n;
	wire s_ck;
	wire s_ck_n;
	wire s_cke;
	wire s_cs_n;
	wire s_ras_n;
	wire s_cas_n;
	wire s_we_n;
	wire s_odt;
	wire [`BANK_BITS-1:0] s_bank;
	wire [ADDR_W-1:0] s_addr;
	assign {s_rst_n, s_ck, s_ck_n, s_cke, s_cs_n, s_ras_n, s_cas_n, s_we_n, s_odt,
		s_bank, s_addr} = syn_w;

	////////////////////////////////////////////////////////////////////////////
	// Link clock edge detection
	reg ck_prev_r;
	wire ck_rise;
	// Differential crossing: true goes high while the complement goes low
	assign ck_rise = s_ck && !s_ck_n && !ck_prev_r;
	wire [3:0] dec_cmd;
	cmd_decode u_dec (
		.cs_n_in(s_cs_n),
		.ras_n_in(s_ras_n),
		.cas_n_in(s_cas_n),
		.we_n_in(s_we_n),
		.cmd_out(dec_cmd)
	);

	////////////////////////////////////////////////////////////////////////////
	// State
	reg [1:0] ps_r;
	reg [1:0] ps_nxt;
	reg [`BANK_COUNT-1:0] open_r;
	reg [`BANK_COUNT-1:0] open_nxt;
	reg [ADDR_W-1:0] mr1_r;
	reg [ADDR_W-1:0] mr2_r;
	reg odt_reg_r;
	reg cke_reg_r;
	wire dev_rst;
	// Pin reset dominates; only the synchronised level is looked at
	assign dev_rst = reset_in || !s_rst_n;

	function bank_hot;
		input [`BANK_BITS-1:0] b;
		input [`BANK_BITS-1:0] idx;
		begin
			bank_hot = (b == idx);
		end
	endfunction

	wire cmd_live;
	// Commands only count while the command buffers are up and clock is enabled
	assign cmd_live = ck_rise && cke_reg_r && s_cke && (ps_r == `PS_ACTIVE);

	integer i;
	always @*
	begin
		ps_nxt = ps_r;
		open_nxt = open_r;
		case (ps_r)
			`PS_ACTIVE:
			begin
				if (ck_rise && cke_reg_r && !s_cke)
				begin
					if (open_r != {`BANK_COUNT{1'b0}})
						ps_nxt = `PS_ACT_PD;
					else if (dec_cmd == `CMD_REF)
						ps_nxt = `PS_SELF_REF;
					else
						ps_nxt = `PS_PRE_PD;
				end
				else if (cmd_live)
				begin
					for (i = 0; i < `BANK_COUNT; i = i + 1)
					begin
						if (dec_cmd == `CMD_ACT && bank_hot(s_bank, i[`BANK_BITS-1:0]))
							open_nxt[i] = 1'b1;
						if (dec_cmd == `CMD_PRE &&
							(s_addr[`ADDR_AP_BIT] || bank_hot(s_bank, i[`BANK_BITS-1:0])))
							open_nxt[i] = 1'b0;
					end
				end
			end
			`PS_PRE_PD, `PS_ACT_PD:
			begin
				if (ck_rise && s_cke)
					ps_nxt = `PS_ACTIVE;
			end
			default:
			begin
				// Exit needs no link edge, the clock may be stopped here
				if (s_cke)
					ps_nxt = `PS_ACTIVE;
			end
		endcase
	end

	// Termination can follow the control pin only while a mode register enables it
	function rtt_enabled;
		input [ADDR_W-1:0] mr1;
		input [ADDR_W-1:0] mr2;
		begin
			rtt_enabled = mr1[`MR1_RTT_LO] || mr1[`MR1_RTT_MID] || mr1[`MR1_RTT_HI] ||
				mr2[`MR2_RTTWR_LO] || mr2[`MR2_RTTWR_HI];
		end
	endfunction

	// Clocks, drivers and command buffers run only in the active state
	function ps_awake;
		input [1:0] ps;
		begin
			ps_awake = (ps == `PS_ACTIVE);
		end
	endfunction

	// Clock and termination buffers stay up everywhere except self-refresh
	function ps_clocked;
		input [1:0] ps;
		begin
			ps_clocked = (ps != `PS_SELF_REF);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// Output next values
	reg cmd_valid_nxt;
	reg [3:0] cmd_nxt;
	reg [`BANK_BITS-1:0] cmd_bank_nxt;
	reg [ADDR_W-1:0] cmd_addr_nxt;
	reg awake_nxt;
	reg clocked_nxt;
	reg term_en_nxt;
	reg auto_sr_nxt;
	reg ext_sr_nxt;
	always @*
	begin
		// Command outputs rest at deselect between link edges
		cmd_valid_nxt = 1'b0;
		cmd_nxt = `CMD_DESEL;
		cmd_bank_nxt = {`BANK_BITS{1'b0}};
		cmd_addr_nxt = {ADDR_W{1'b0}};
		if (cmd_live)
		begin
			cmd_valid_nxt = (dec_cmd != `CMD_DESEL);
			cmd_nxt = dec_cmd;
			cmd_bank_nxt = s_bank;
			cmd_addr_nxt = s_addr;
		end
		awake_nxt = ps_awake(ps_nxt);
		clocked_nxt = ps_clocked(ps_nxt);
		// Termination off when both mode registers leave it disabled
		term_en_nxt = odt_reg_r && clocked_nxt && rtt_enabled(mr1_r, mr2_r);
		auto_sr_nxt = mr2_r[`MR2_AUTO_SR_BIT];
		// Automatic mode takes over, so the manual extended flag is masked with it
		ext_sr_nxt = !mr2_r[`MR2_AUTO_SR_BIT] && mr2_r[`MR2_SRT_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// Link-sampled state and mode registers
	always @(posedge ref_clk_in)
	begin
		if (dev_rst)
		begin
			ck_prev_r <= 1'b0;
			ps_r <= `PS_ACTIVE;
			open_r <= {`BANK_COUNT{1'b0}};
			mr1_r <= {ADDR_W{1'b0}};
			mr2_r <= {ADDR_W{1'b0}};
			odt_reg_r <= 1'b0;
			cke_reg_r <= 1'b0;
		end
		else
		begin
			ck_prev_r <= s_ck && !s_ck_n;
			ps_r <= ps_nxt;
			open_r <= open_nxt;
			if (ck_rise && ps_r != `PS_SELF_REF)
			begin
				cke_reg_r <= s_cke;
				odt_reg_r <= s_odt;
			end
			else if (ps_r == `PS_SELF_REF)
				cke_reg_r <= s_cke;
			if (cmd_live && dec_cmd == `CMD_MRS)
			begin
				if (s_bank == `MR_SEL_1)
					mr1_r <= s_addr;
				if (s_bank == `MR_SEL_2)
					mr2_r <= s_addr;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Output registers: every output comes straight from a flip-flop
	always @(posedge ref_clk_in)
	begin
		if (dev_rst)
		begin
			cmd_valid_out <= 1'b0;
			cmd_out <= `CMD_DESEL;
			cmd_bank_out <= {`BANK_BITS{1'b0}};
			cmd_addr_out <= {ADDR_W{1'b0}};
			power_state_out <= `PS_ACTIVE;
			int_clk_en_out <= 1'b0;
			out_drv_en_out <= 1'b0;
			cmd_buf_en_out <= 1'b0;
			ck_buf_en_out <= 1'b0;
			odt_buf_en_out <= 1'b0;
			term_en_out <= 1'b0;
			bank_open_out <= {`BANK_COUNT{1'b0}};
			auto_self_refresh_out <= 1'b0;
			ext_temp_sr_out <= 1'b0;
		end
		else
		begin
			cmd_valid_out <= cmd_valid_nxt;
			cmd_out <= cmd_nxt;
			cmd_bank_out <= cmd_bank_nxt;
			cmd_addr_out <= cmd_addr_nxt;
			power_state_out <= ps_nxt;
			int_clk_en_out <= awake_nxt;
			out_drv_en_out <= awake_nxt;
			cmd_buf_en_out <= awake_nxt;
			ck_buf_en_out <= clocked_nxt;
			odt_buf_en_out <= clocked_nxt;
			term_en_out <= term_en_nxt;
			bank_open_out <= open_nxt;
			auto_self_refresh_out <= auto_sr_nxt;
			ext_temp_sr_out <= ext_sr_nxt;
		end
	end
endmodule

// >>> testbench/ddr3_ctl_pins_props.sv
// Port checker for the DDR3 command and control input block
`timescale 1ns/1ns
`include "ddr3_ctl_map.vh"
module ddr3_ctl_pins_props (
	// Clock, reset and pins
	input wire ref_clk_in,
	input wire reset_in,
	input wire reset_n_pin_in,
	input wire cke_in,
	input wire cs_n_in,
	input wire odt_in,
	// Block outputs
	input wire cmd_valid_out,
	input wire [3:0] cmd_out,
	input wire [1:0] power_state_out,
	input wire int_clk_en_out,
	input wire out_drv_en_out,
	input wire cmd_buf_en_out,
	input wire ck_buf_en_out,
	input wire odt_buf_en_out,
	input wire term_en_out,
	input wire [7:0] bank_open_out,
	input wire auto_self_refresh_out,
	input wire ext_temp_sr_out
);
	default clocking dc @(posedge ref_clk_in);
	endclocking
	default disable iff (reset_in);
	// Pins are held four cycles either side of the link rise, so three back is inside
	cmd_mask_a: assert property (cmd_valid_out |-> !$past(cs_n_in, 3) && !cmd_out[3])
		else $error("command accepted with chip select high");
	cmd_active_a: assert property (cmd_valid_out |-> power_state_out == `PS_ACTIVE && $past(cke_in, 3))
		else $error("command accepted outside active state");
	idle_bufs_a: assert property (power_state_out != `PS_ACTIVE |-> !int_clk_en_out && !out_drv_en_out && !cmd_buf_en_out)
		else $error("clocks or buffers running while powered down");
	pd_bufs_a: assert property (power_state_out inside {`PS_PRE_PD, `PS_ACT_PD} |-> ck_buf_en_out && odt_buf_en_out)
		else $error("clock or termination buffer off in power-down");
	sr_bufs_a: assert property (power_state_out == `PS_SELF_REF |-> !ck_buf_en_out && !odt_buf_en_out)
		else $error("buffer left on in self-refresh");
	apd_entry_a: assert property (power_state_out == `PS_ACT_PD && $past(power_state_out) == `PS_ACTIVE |-> $past(bank_open_out) != 8'h00)
		else $error("active power-down with all banks idle");
	ppd_entry_a: assert property (power_state_out == `PS_PRE_PD && $past(power_state_out) == `PS_ACTIVE |-> $past(bank_open_out) == 8'h00)
		else $error("precharge power-down with a row open");
	sr_exit_a: assert property (cke_in && power_state_out == `PS_SELF_REF |-> ##[1:5] power_state_out == `PS_ACTIVE)
		else $error("self-refresh not left on clock enable");
	sr_term_a: assert property (power_state_out == `PS_SELF_REF [*3] |-> !term_en_out)
		else $error("termination on in self-refresh");
	odt_low_a: assert property (!odt_in [*8] |-> ##[0:12] !term_en_out)
		else $error("termination stays on with control low");
	pin_reset_a: assert property (!reset_n_pin_in [*4] |-> bank_open_out == 8'h00 && !cmd_valid_out)
		else $error("state survives pin reset");
	sr_mode_a: assert property (!(auto_self_refresh_out && ext_temp_sr_out))
		else $error("both self-refresh modes reported");
endmodule
bind ddr3_ctl_pins ddr3_ctl_pins_props ddr3_ctl_pins_props_inst (.ref_clk_in(ref_clk_in),
	.reset_in(reset_in), .reset_n_pin_in(reset_n_pin_in), .cke_in(cke_in), .cs_n_in(cs_n_in),
	.odt_in(odt_in), .cmd_valid_out(cmd_valid_out), .cmd_out(cmd_out),
	.power_state_out(power_state_out), .int_clk_en_out(int_clk_en_out),
	.out_drv_en_out(out_drv_en_out), .cmd_buf_en_out(cmd_buf_en_out),
	.ck_buf_en_out(ck_buf_en_out), .odt_buf_en_out(odt_buf_en_out), .term_en_out(term_en_out),
	.bank_open_out(bank_open_out), .auto_self_refresh_out(auto_self_refresh_out),
	.ext_temp_sr_out(ext_temp_sr_out));

// >>> testbench/ddr3_link_model.sv
// Controller-side model: link clock, clock enable and command pins
`timescale 1ns/1ns
module ddr3_link_model (
	// System clock
	input wire ref_clk_in,
	// Link pins
	output reg ck_out = 1'b0,
	output wire ck_n_out,
	output reg cke_out = 1'b1,
	output reg [3:0] cmd_out = 4'hf,
	output reg [2:0] bank_out = 3'h0,
	output reg [13:0] addr_out = 14'h0000
);
	reg ck_run = 1'b1;
	reg [1:0] div_r = 2'h0;
	// Auto-refresh spacing in ns the controller keeps when hot; bench runs cool and short
	localparam integer refresh_interval = 3900;
	assign ck_n_out = ~ck_out;
	// Clock can be stopped in self-refresh, so the block must not need it to wake
	always @(negedge ref_clk_in)
	begin
		div_r <= div_r + 2'h1;
		if (ck_run && div_r == 2'h3)
			ck_out <= ~ck_out;
	end
	// Pins set at one link fall, held over the rise, then scrambled
	task issue(input [3:0] c, input [2:0] b, input [13:0] a, input k);
	begin
		@(negedge ck_out);
		cmd_out <= c;
		bank_out <= b;
		addr_out <= a;
		cke_out <= k;
		@(negedge ck_out);
		cmd_out <= {1'b1, ~c[2:0]};
		bank_out <= ~b;
		addr_out <= ~a;
	end
	endtask
endmodule

// >>> testbench/ddr3_ctl_pins_test.sv
// Self-checking bench for the DDR3 command and control input block
`timescale 1ns/1ns
`include "ddr3_ctl_map.vh"
module ddr3_ctl_pins_test;
	reg ref_clk_in = 1'b0;
	reg reset_in = 1'b1;
	reg reset_n_pin_in = 1'b1;
	reg odt_in = 1'b0;
	wire ck, ck_n, cke, cmd_valid_out, int_clk_en_out, out_drv_en_out, cmd_buf_en_out;
	wire ck_buf_en_out, odt_buf_en_out, term_en_out, auto_self_refresh_out, ext_temp_sr_out;
	wire [3:0] pins;
	wire [3:0] cmd_out;
	wire [2:0] bank;
	wire [2:0] cmd_bank_out;
	wire [13:0] addr;
	wire [13:0] cmd_addr_out;
	wire [1:0] power_state_out;
	wire [7:0] bank_open_out;
	integer num_errors = 0;
	integer samples_checked = 0;
	integer n_valid = 0;
	integer i;
	integer n0;
	reg [6:0] got = 7'h00;
	reg [13:0] got_addr = 14'h0000;
	always #50 ref_clk_in = ~ref_clk_in;
	ddr3_link_model ddr3_link_model_inst (.ref_clk_in(ref_clk_in), .ck_out(ck), .ck_n_out(ck_n),
		.cke_out(cke), .cmd_out(pins), .bank_out(bank), .addr_out(addr));
	ddr3_ctl_pins ddr3_ctl_pins_inst (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
		.reset_n_pin_in(reset_n_pin_in), .ck_in(ck), .ck_n_in(ck_n), .cke_in(cke),
		.cs_n_in(pins[3]), .ras_n_in(pins[2]), .cas_n_in(pins[1]), .we_n_in(pins[0]),
		.odt_in(odt_in), .bank_in(bank), .addr_in(addr), .cmd_valid_out(cmd_valid_out),
		.cmd_out(cmd_out), .cmd_bank_out(cmd_bank_out), .cmd_addr_out(cmd_addr_out),
		.power_state_out(power_state_out), .int_clk_en_out(int_clk_en_out),
		.out_drv_en_out(out_drv_en_out), .cmd_buf_en_out(cmd_buf_en_out),
		.ck_buf_en_out(ck_buf_en_out), .odt_buf_en_out(odt_buf_en_out), .term_en_out(term_en_out),
		.bank_open_out(bank_open_out), .auto_self_refresh_out(auto_self_refresh_out),
		.ext_temp_sr_out(ext_temp_sr_out));
	always @(posedge ref_clk_in)
		if (cmd_valid_out === 1'b1)
		begin
			n_valid <= n_valid + 1;
			got <= {cmd_out, cmd_bank_out};
			got_addr <= cmd_addr_out;
		end
	task check(input [31:0] seen, input [31:0] exp);
	begin
		samples_checked = samples_checked + 1;
		if (seen !== exp)
		begin
			num_errors = num_errors + 1;
			$display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
		end
	end
	endtask
	// Two link periods per command; decoded result has landed when this returns
	task cmd(input [3:0] c, input [2:0] b, input [13:0] a, input k);
	begin
		n0 = n_valid;
		ddr3_link_model_inst.issue(c, b, a, k);
		repeat (4) @(negedge ref_clk_in);
	end
	endtask
	task conclude;
	begin
		$display("Checks %0d, errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	end
	endtask
	initial
	begin
		#500000;
		num_errors = num_errors + 1;
		conclude;
	end
	initial
	begin
		repeat (4) @(negedge ref_clk_in);
		reset_in = 1'b0;
		cmd(4'h7, 3'h0, 14'h0000, 1'b1);
		cmd(4'h8, 3'h3, 14'h0000, 1'b1);
		check(n_valid - n0, 0);
		for (i = 0; i < 8; i = i + 1)
		begin
			cmd(i[3:0], i[2:0], 14'h1230 | i[13:0], 1'b1);
			check(n_valid - n0, 1);
			check(got, {i[3:0], i[2:0]});
			check(got_addr, 14'h1230 | i[13:0]);
		end
		check(bank_open_out, 8'h08);
		odt_in = 1'b1;
		cmd(4'h7, 3'h0, 14'h0000, 1'b1);
		check(term_en_out, 0);
		cmd(4'h0, 3'h1, 14'h0004, 1'b1);
		check(term_en_out, 1);
		cmd(4'h7, 3'h0, 14'h0000, 1'b0);
		check(power_state_out, `PS_ACT_PD);
		check({int_clk_en_out, out_drv_en_out, cmd_buf_en_out, ck_buf_en_out, odt_buf_en_out}, 3);
		cmd(4'h3, 3'h6, 14'h0000, 1'b0);
		check(n_valid - n0, 0);
		cmd(4'h7, 3'h0, 14'h0000, 1'b1);
		check(power_state_out, `PS_ACTIVE);
		cmd(4'h2, 3'h0, 14'h0400, 1'b1);
		check(bank_open_out, 8'h00);
		cmd(4'h0, 3'h2, 14'h0080, 1'b1);
		check({auto_self_refresh_out, ext_temp_sr_out}, 1);
		cmd(4'h0, 3'h2, 14'h0040, 1'b1);
		check({auto_self_refresh_out, ext_temp_sr_out}, 2);
		cmd(4'h1, 3'h0, 14'h0000, 1'b0);
		check(power_state_out, `PS_SELF_REF);
		check({ck_buf_en_out, odt_buf_en_out, cmd_buf_en_out, term_en_out}, 0);
		ddr3_link_model_inst.ck_run = 1'b0;
		repeat (8) @(negedge ref_clk_in);
		ddr3_link_model_inst.cke_out <= 1'b1;
		repeat (8) @(negedge ref_clk_in);
		check(power_state_out, `PS_ACTIVE);
		ddr3_link_model_inst.ck_run = 1'b1;
		cmd(4'h7, 3'h0, 14'h0000, 1'b1);
		cmd(4'h7, 3'h0, 14'h0000, 1'b0);
		check(power_state_out, `PS_PRE_PD);
		cmd(4'h7, 3'h0, 14'h0000, 1'b1);
		cmd(4'h3, 3'h1, 14'h0000, 1'b1);
		check(bank_open_out, 8'h02);
		odt_in = 1'b0;
		cmd(4'h7, 3'h0, 14'h0000, 1'b1);
		check(term_en_out, 0);
		reset_n_pin_in = 1'b0;
		repeat (6) @(negedge ref_clk_in);
		check(bank_open_out, 8'h00);
		reset_n_pin_in = 1'b1;
		conclude;
	end
endmodule
